// File: dv/platform_model.sv
// Platform side: power-good and processor reset sequencing.
// Assumes the bench raises pg_on to ask for power and drops it to cut power.
`timescale 1ns/1ps
module platform_model
#(
    parameter int STABLE_CYC = 20, // Supplies settle before power-good
    parameter int RST_CYC = 200    // Stands in for the ms-long pulse, keeps runs short
)
(
    input wire logic ref_clk, // Bus clock
    input wire logic pg_on,   // Bench request: supplies on
    output logic power_good,  // Always driven, never floating
    output logic bus_reset_n  // Processor reset, active low
);
    int cnt = 0;

    initial
    begin
        power_good = 1'b0;
        bus_reset_n = 1'b0;
    end

    always @(posedge ref_clk)
    begin
        if (!pg_on)
        begin
            power_good <= 1'b0; // Drop allowed at any time
            bus_reset_n <= 1'b0; // Held while power is off
            cnt <= 0; // New rise waits for settling again
        end
        else
        begin
            if (cnt < STABLE_CYC + RST_CYC)
                cnt <= cnt + 1;
            if (cnt == STABLE_CYC)
                power_good <= 1'b1; // Low till stable, one clean rise, then held
            if (cnt == STABLE_CYC + RST_CYC)
                bus_reset_n <= 1'b1; // Bounded pulse after each rise
        end
    end
endmodule : platform_model

// File: dv/tb.sv
// Self-checking bench for the sideband block: table of pin and control cases,
// then hand-written power, error-line and register cases. Single 200 MHz clock.
`timescale 1ns/1ps
`include "sideband_defines.svh"
module tb;
    import sideband_pkg::*;

    typedef struct packed {
        ctrl_t ctrl;
        logic [2:0] pins; // strap, trip, initiator
        logic [3:0] want; // termination, alert_n, thermal control, drives line
    } row_t;

    row_t rows [7] = '{'{4'hF, 3'h5, 4'hD}, '{4'h0, 3'h3, 4'h0}, '{4'hB, 3'h7, 4'hB},
        '{4'hB, 3'h0, 4'h4}, '{4'h5, 3'h4, 4'hD}, '{4'hE, 3'h1, 4'h4}, '{4'h9, 3'h3, 4'h2}};
    logic ref_clk, resetn, pg_on, termination_enable_strap, platform_type_select, die_trip;
    logic txn_error, txn_initiator, other_drive, power_good, bus_reset_n;
    logic machine_check_error_in, machine_check_error_out, machine_check_error_oe;
    logic thermal_alert_n, thermal_control_active, termination_active, platform_optimized;
    logic bus_out_en, core_run, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, hi;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;

    // Pull-up line, any agent may pull it low
    assign machine_check_error_in = (machine_check_error_oe ? machine_check_error_out : 1'b1)
        & ~other_drive;

    platform_model platform_model_inst (.ref_clk, .pg_on, .power_good, .bus_reset_n);

    sideband sideband_inst (.ref_clk, .resetn, .power_good, .bus_reset_n,
        .termination_enable_strap, .platform_type_select, .die_trip, .txn_error,
        .txn_initiator, .machine_check_error_in, .machine_check_error_out,
        .machine_check_error_oe, .thermal_alert_n, .thermal_control_active,
        .termination_active,
        .platform_optimized, .bus_out_en, .core_run, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Hang guard, runs need well under this
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    // Address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axr

    task automatic do_reset();
        @(posedge ref_clk);
        resetn <= 1'b0;
        tick(6);
        resetn <= 1'b1;
    endtask : do_reset

    task automatic pwr_up();
        @(posedge ref_clk);
        pg_on <= 1'b1;
        do
            @(posedge ref_clk);
        while (!core_run);
        tick(8);
    endtask : pwr_up

    initial
    begin
        {resetn, pg_on, termination_enable_strap, platform_type_select, die_trip} = 5'h0;
        {txn_error, txn_initiator, other_drive, s_axi_awvalid, s_axi_wvalid} = 5'h0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 19'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        do_reset();
        rd = 32'({thermal_alert_n, machine_check_error_oe, machine_check_error_out, bus_out_en});
        chk(rd, 32'h8);
        axr(`SB_OFS_CTRL, rd, rsp);
        chk(rd, 32'h0000000F);
        $display("test reset done");
        pwr_up();
        chk(32'({bus_out_en, platform_optimized}), 32'h2);
        foreach (rows[i])
        begin
            axw(`SB_OFS_CTRL, {28'h0, rows[i].ctrl}, rsp);
            axr(`SB_OFS_CTRL, rd, rsp);
            chk(rd, {28'h0, rows[i].ctrl});
            {termination_enable_strap, die_trip, txn_initiator} <= rows[i].pins;
            tick(8);
            rd = 32'({termination_active, thermal_alert_n, thermal_control_active});
            chk(rd, 32'(rows[i].want[3:1]));
            txn_error <= 1'b1;
            @(posedge ref_clk);
            txn_error <= 1'b0;
            hi = 32'h0;
            // Counts drive enable and the line really pulled low, two cycles each
            repeat (10)
            begin
                @(posedge ref_clk);
                hi = hi + 32'(machine_check_error_oe) + 32'(!machine_check_error_in);
            end
            chk(hi, rows[i].want[0] ? 32'h4 : 32'h0);
        end
        $display("test table done");
        axw(`SB_OFS_EVENT, 32'h7, rsp);
        axr(`SB_OFS_EVENT, rd, rsp);
        chk(rd & 32'h1, 32'h0);
        other_drive <= 1'b1;
        tick(10);
        axr(`SB_OFS_STATUS, rd, rsp);
        chk(32'({rd[7], machine_check_error_oe}), 32'h2);
        other_drive <= 1'b0;
        tick(10);
        axr(`SB_OFS_EVENT, rd, rsp);
        chk(rd & 32'h1, 32'h1);
        $display("test shared line done");
        axw(8'h0C, 32'hFF, rsp);
        chk(32'(rsp), 32'(`SB_RESP_SLVERR));
        axr(8'h0C, rd, rsp);
        chk(rd, 32'h0);
        chk(32'(rsp), 32'(`SB_RESP_SLVERR));
        $display("test unmapped done");
        axw(`SB_OFS_CTRL, 32'hF, rsp);
        txn_initiator <= 1'b1;
        txn_error <= 1'b1;
        @(posedge ref_clk);
        txn_error <= 1'b0;
        pg_on <= 1'b0;
        platform_type_select <= 1'b1;
        tick(8);
        chk(32'({bus_out_en, machine_check_error_oe, core_run}), 32'h0);
        axr(`SB_OFS_EVENT, rd, rsp);
        chk(rd & 32'h2, 32'h2);
        pwr_up();
        chk(32'(platform_optimized), 32'h1);
        platform_type_select <= 1'b0;
        tick(8);
        chk(32'(platform_optimized), 32'h1);
        $display("test power cycle done");
        axw(`SB_OFS_CTRL, 32'h0, rsp);
        do_reset();
        axr(`SB_OFS_CTRL, rd, rsp);
        chk(rd, 32'h0000000F);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule : tb

// File: include/sideband_defines.svh
// Offsets, field positions, reset values and timing counts of the sideband block.
// Assumes a 200 MHz bus clock and a 32-bit AXI4-Lite register port.
`ifndef SIDEBAND_DEFINES_SVH
`define SIDEBAND_DEFINES_SVH

`define SB_CLK_MHZ 200
`define SB_OFS_CTRL 8'h00
`define SB_OFS_STATUS 8'h04
`define SB_OFS_EVENT 8'h08
`define SB_CTRL_RESET 4'hF
`define SB_EV_MCE_BIT 0
`define SB_EV_PGFALL_BIT 1
`define SB_EV_TRIP_BIT 2
`define SB_BUS_RELEASE_CLK 2
`define SB_MCE_DRIVE_PHASE 2'h0
`define SB_MCE_SAMPLE_PHASE 2'h2
`define SB_MCE_DRIVE_CYC 2'h2
`define SB_RESP_OKAY 2'h0
`define SB_RESP_SLVERR 2'h2

`endif

// File: include/sideband_pkg.sv
// Types shared by the sideband block: control register layout and error drive states.
// Assumes the constants of sideband_defines.svh are included where offsets are needed.
package sideband_pkg;

    typedef struct packed {
        logic thermal_control_en; // Thermal control circuit enable
        logic obs_en;      // Assert on errors seen from any agent
        logic init_en;     // Assert on errors of own transactions
        logic mce_en;      // Master enable of the error line
    } ctrl_t;

    typedef enum logic [2:0] {
        MCE_IDLE  = 3'b001,
        MCE_WAIT  = 3'b010,
        MCE_DRIVE = 3'b100
    } mce_state_t;

endpackage : sideband_pkg

// File: rtl/sideband.sv
// Processor sideband logic: power-good and reset observation, shared machine-check
// line, thermal alert and straps. Registers over AXI4-Lite on ref_clk.
// Assumes the pin inputs are asynchronous and the error inputs come from ref_clk logic.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "sideband_defines.svh"

module pin_sync
(
    input wire logic ref_clk,   // Bus clock
    input wire logic resetn,    // Synchronous reset, active low
    input wire logic init,      // Value taken at reset
    input wire logic pin,       // Asynchronous level
    output logic level          // Filtered level
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge ref_clk)
    begin
        s1 <= pin;
        s2 <= s1;
        s3 <= s2;
    end

    // Only a level that stood on two stages is accepted
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            level <= init;
        else if (s2 == s3)
            level <= s3;
    end
endmodule : pin_sync

module sideband
(
    input wire logic ref_clk,                   // Bus clock, 200 MHz
    input wire logic resetn,                    // Synchronous reset, active low
    input wire logic power_good,                // Platform power-good pin
    input wire logic bus_reset_n,               // Platform processor reset pin
    input wire logic termination_enable_strap,  // On-die termination strap
    input wire logic platform_type_select,      // High selects optimized platform
    input wire logic die_trip,                  // Sensor at trip point, async
    input wire logic txn_error,                 // Error seen in a bus transaction
    input wire logic txn_initiator,             // That transaction was our own
    input wire logic machine_check_error_in,    // Error line level, active low
    output logic machine_check_error_out,       // Error line drive value
    output logic machine_check_error_oe,        // Error line drive enable
    output logic thermal_alert_n,               // Thermal alert, active low
    output logic thermal_control_active,        // Thermal control engaged
    output logic termination_active,            // On-die termination on
    output logic platform_optimized,            // Platform type captured at reset
    output logic bus_out_en,                    // Bus outputs may drive
    output logic core_run,                      // Core out of reset and powered
    input wire logic [7:0] s_axi_awaddr,        // Write address
    input wire logic s_axi_awvalid,             // Write address valid
    output logic s_axi_awready,                 // Write address ready
    input wire logic [31:0] s_axi_wdata,        // Write data
    input wire logic [3:0] s_axi_wstrb,         // Write strobes
    input wire logic s_axi_wvalid,              // Write data valid
    output logic s_axi_wready,                  // Write data ready
    output logic [1:0] s_axi_bresp,             // Write response
    output logic s_axi_bvalid,                  // Write response valid
    input wire logic s_axi_bready,              // Write response ready
    input wire logic [7:0] s_axi_araddr,        // Read address
    input wire logic s_axi_arvalid,             // Read address valid
    output logic s_axi_arready,                 // Read address ready
    output logic [31:0] s_axi_rdata,            // Read data
    output logic [1:0] s_axi_rresp,             // Read response
    output logic s_axi_rvalid,                  // Read data valid
    input wire logic s_axi_rready               // Read data ready
);
    import sideband_pkg::*;

    sideband_pkg::ctrl_t ctrl;
    mce_state_t mce_state;
    logic pg_s;
    logic rst_n_s;
    logic rst_n_d;
    logic pg_d;
    logic term_s;
    logic plat_s;
    logic trip_s;
    logic mce_line_n_s;
    logic [1:0] phase;
    logic [1:0] drive_cnt;
    logic mce_sampled;
    logic [2:0] events;
    logic mce_req;
    logic [7:0] aw_addr;
    logic aw_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_have;
    logic wr_fire;
    logic [2:0] ev_clr;

    pin_sync u_pg (.ref_clk(ref_clk), .resetn(resetn), .init(1'b0), .pin(power_good),
        .level(pg_s));
    pin_sync u_rst (.ref_clk(ref_clk), .resetn(resetn), .init(1'b0), .pin(bus_reset_n),
        .level(rst_n_s));
    pin_sync u_term (.ref_clk(ref_clk), .resetn(resetn), .init(1'b0),
        .pin(termination_enable_strap), .level(term_s));
    pin_sync u_plat (.ref_clk(ref_clk), .resetn(resetn), .init(1'b0),
        .pin(platform_type_select), .level(plat_s));
    pin_sync u_trip (.ref_clk(ref_clk), .resetn(resetn), .init(1'b0), .pin(die_trip),
        .level(trip_s));
    pin_sync u_mce (.ref_clk(ref_clk), .resetn(resetn), .init(1'b1),
        .pin(machine_check_error_in), .level(mce_line_n_s));

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            rst_n_d <= 1'b0;
            pg_d <= 1'b0;
        end
        else
        begin
            rst_n_d <= rst_n_s;
            pg_d <= pg_s;
        end
    end

    // Bus outputs dropped the cycle after reset is seen, well inside two clocks
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            bus_out_en <= 1'b0;
            core_run <= 1'b0;
        end
        else
        begin
            bus_out_en <= rst_n_s;
            core_run <= rst_n_s && pg_s;
        end
    end

    // Straps: termination follows the strap level at all times
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            termination_active <= 1'b0;
            platform_optimized <= 1'b0;
        end
        else
        begin
            termination_active <= term_s;
            if (rst_n_s && !rst_n_d)
                platform_optimized <= plat_s;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            thermal_alert_n <= 1'b1;
            thermal_control_active <= 1'b0;
        end
        else
        begin
            thermal_alert_n <= !trip_s;
            thermal_control_active <= trip_s && ctrl.thermal_control_en;
        end
    end

    // Drive and sample edges are fixed phases of a shared cadence so that
    // simultaneous drivers only ever switch together
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            phase <= 2'h0;
        else
            phase <= phase + 2'h1;
    end

    assign mce_req = ctrl.mce_en && rst_n_s && txn_error
        && ((txn_initiator && ctrl.init_en) || ctrl.obs_en);

    always_ff @(posedge ref_clk)
    begin
        if (!resetn || !rst_n_s)
        begin
            mce_state <= MCE_IDLE;
            machine_check_error_oe <= 1'b0;
            drive_cnt <= 2'h0;
        end
        else
        begin
            case (mce_state)
                MCE_IDLE:
                    if (mce_req)
                        mce_state <= MCE_WAIT;
                MCE_WAIT:
                    if (phase == `SB_MCE_DRIVE_PHASE)
                    begin
                        mce_state <= MCE_DRIVE;
                        machine_check_error_oe <= 1'b1;
                        drive_cnt <= 2'h1;
                    end
                MCE_DRIVE:
                    if (drive_cnt == `SB_MCE_DRIVE_CYC)
                    begin
                        mce_state <= MCE_IDLE;
                        machine_check_error_oe <= 1'b0;
                    end
                    else
                        drive_cnt <= drive_cnt + 2'h1;
                default:
                begin
                    mce_state <= MCE_IDLE;
                    machine_check_error_oe <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            machine_check_error_out <= 1'b0;
            mce_sampled <= 1'b0;
        end
        else
        begin
            machine_check_error_out <= 1'b0;
            if (phase == `SB_MCE_SAMPLE_PHASE)
                mce_sampled <= !mce_line_n_s;
        end
    end

    // Sticky events; a set in the clearing cycle wins
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            events <= 3'h0;
        else
        begin
            events[`SB_EV_MCE_BIT] <= mce_sampled
                || (events[`SB_EV_MCE_BIT] && !ev_clr[`SB_EV_MCE_BIT]);
            events[`SB_EV_PGFALL_BIT] <= (pg_d && !pg_s)
                || (events[`SB_EV_PGFALL_BIT] && !ev_clr[`SB_EV_PGFALL_BIT]);
            events[`SB_EV_TRIP_BIT] <= trip_s
                || (events[`SB_EV_TRIP_BIT] && !ev_clr[`SB_EV_TRIP_BIT]);
        end
    end

    // Write channel: address and data taken in either order, one at a time
    assign wr_fire = aw_have && w_have && !s_axi_bvalid;
    assign ev_clr = (wr_fire && aw_addr == `SB_OFS_EVENT && w_strb[0]) ? w_data[2:0] : 3'h0;

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SB_RESP_OKAY;
            ctrl <= `SB_CTRL_RESET;
        end
        else
        begin
            s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_have && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `SB_RESP_OKAY;
                if (aw_addr == `SB_OFS_CTRL)
                begin
                    if (w_strb[0])
                        ctrl <= w_data[3:0];
                end
                else if (aw_addr != `SB_OFS_EVENT)
                    s_axi_bresp <= `SB_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `SB_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `SB_RESP_OKAY;
            case (s_axi_araddr)
                `SB_OFS_CTRL: s_axi_rdata <= {28'h0, ctrl};
                `SB_OFS_STATUS: s_axi_rdata <= {24'h0, mce_sampled, machine_check_error_oe,
                    platform_optimized, term_s, trip_s, rst_n_s, pg_s, core_run};
                `SB_OFS_EVENT: s_axi_rdata <= {29'h0, events};
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `SB_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
        else
            s_axi_arready <= 1'b1;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_bus_release: assert property (rst_n_d && !rst_n_s |=> !bus_out_en)
        else $error("bus outputs not released after reset");
    a_drive_phase: assert property ($rose(machine_check_error_oe)
        |-> $past(phase) == `SB_MCE_DRIVE_PHASE)
        else $error("error line driven off its phase");
    // A processor reset cuts a drive short on purpose, so it stops the check
    a_drive_length: assert property (disable iff (!resetn || !rst_n_s)
        $rose(machine_check_error_oe) |-> machine_check_error_oe[*2] ##1 !machine_check_error_oe)
        else $error("error line drive length wrong");
    a_mce_disabled: assert property (mce_state == MCE_IDLE && !ctrl.mce_en
        |=> mce_state == MCE_IDLE)
        else $error("error line armed while disabled");
    a_init_error: assert property (mce_state == MCE_IDLE && txn_error
        && txn_initiator && ctrl.init_en && ctrl.mce_en && rst_n_s |=> mce_state == MCE_WAIT)
        else $error("own error not armed");
    a_obs_error: assert property (disable iff (!resetn || !rst_n_s)
        mce_state == MCE_IDLE && txn_error && ctrl.obs_en && ctrl.mce_en
        |=> mce_state == MCE_WAIT ##[1:4] machine_check_error_oe)
        else $error("observed error not driven in time");
    a_thermal: assert property (trip_s |=> !thermal_alert_n)
        else $error("thermal alert missing at trip");
    a_termination: assert property (term_s |=> termination_active)
        else $error("termination off while strap high");
    a_platform_type: assert property (rst_n_s && !rst_n_d
        |=> platform_optimized == $past(plat_s))
        else $error("platform type not captured");

    c_mce_drive: cover property ($rose(machine_check_error_oe));
    c_thermal: cover property ($fell(thermal_alert_n));
    c_pg_fall: cover property ($rose(events[`SB_EV_PGFALL_BIT]));
    c_reset_release: cover property ($rose(bus_out_en));

endmodule : sideband
